// ### mmc_pkg.sv
// constants shared by the management control block and its serial slave
// assumes a 25 MHz system clock and a byte-wide management address space
package mmc_pkg;

  // clock rate
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned CLK_KHZ = 1000000 / CLK_PERIOD_NS;

  // time figures in their own units
  localparam int unsigned T_INIT_MS = 2000;
  localparam int unsigned T_RESET_MIN_NS = 2000;

  // least reset pulse, rounded up to whole cycles
  localparam logic [7:0] RESET_FILTER_CYCLES =
    8'((T_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // longest init time, rounded down to whole cycles
  localparam int unsigned INIT_CYCLES_DEF = T_INIT_MS * CLK_KHZ;

  // serial slave address, arbitrary neutral value
  localparam logic [6:0] DEV_ADDR_DEF = 7'h50;

  // lower page byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h02;
  localparam logic [7:0] OFS_LOS_FLAG = 8'h03;
  localparam logic [7:0] OFS_TXF_FLAG = 8'h04;
  localparam logic [7:0] OFS_PWR_CTRL = 8'h5d;
  localparam logic [7:0] OFS_CDR = 8'h62;
  localparam logic [7:0] OFS_LOS_MASK = 8'h64;
  localparam logic [7:0] OFS_TXF_MASK = 8'h65;
  localparam logic [7:0] OFS_PAGE = 8'h7f;

  // upper page byte offsets, valid while the page select holds PAGE_CTRL
  localparam logic [7:0] PAGE_CTRL = 8'h03;
  localparam logic [7:0] UPPER_BASE = 8'h80;
  localparam logic [7:0] OFS_TX_EQ = 8'hea;
  localparam logic [7:0] OFS_RX_EMPH = 8'hec;
  localparam logic [7:0] OFS_RX_AMP = 8'hee;

  // field positions
  localparam int unsigned BIT_DATA_NOT_READY = 0;
  localparam int unsigned BIT_PWR_OVERRIDE = 0;
  localparam int unsigned TX_CDR_LSB = 4;
  localparam int unsigned RX_CDR_LSB = 0;

  // highest legal code of each 4-bit lane setting
  localparam logic [3:0] EQ_MAX_CODE = 4'ha;
  localparam logic [3:0] EMPH_MAX_CODE = 4'h7;
  localparam logic [3:0] AMP_MAX_CODE = 4'h3;

  // values after reset
  localparam logic [7:0] RST_CDR = 8'h00;
  localparam logic [15:0] RST_LANE_CODES = 16'h0000;
  localparam logic [3:0] RST_MASK = 4'h0;
  localparam logic [7:0] RST_PAGE = 8'h00;

  // module readiness states
  typedef enum logic [1:0] {
    MMC_ST_INIT = 2'b01,
    MMC_ST_READY = 2'b10
  } mmc_state_e;

  // serial slave states
  typedef enum logic [6:0] {
    MMC_TW_IDLE = 7'b0000001,
    MMC_TW_ADDR = 7'b0000010,
    MMC_TW_AACK = 7'b0000100,
    MMC_TW_WBYTE = 7'b0001000,
    MMC_TW_WACK = 7'b0010000,
    MMC_TW_RBYTE = 7'b0100000,
    MMC_TW_RACK = 7'b1000000
  } mmc_tw_state_e;

endpackage

// ### mmc_bus_if.sv
// byte access carrier between the serial slave and the register bank
// assumes both ends run on one clock; strobes are one-cycle pulses
`timescale 1ns/1ps
interface mmc_bus_if;
  logic enable;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr_en;
  logic rd_en;
  logic stop_wr;
  logic stop_rd;
  logic [7:0] rdata;

  modport slave (
    input enable,
    input rdata,
    output addr,
    output wdata,
    output wr_en,
    output rd_en,
    output stop_wr,
    output stop_rd
  );

  modport regs (
    output enable,
    output rdata,
    input addr,
    input wdata,
    input wr_en,
    input rd_en,
    input stop_wr,
    input stop_rd
  );
endinterface

// ### mmc_twi_slave.sv
// two-wire serial slave: address match, pointer, byte writes and reads
// assumes scl and sda are synchronous to clk and far slower than it
`timescale 1ns/1ps
module mmc_twi_slave #(
  parameter logic [6:0] DEV_ADDR = mmc_pkg::DEV_ADDR_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_oe,
  mmc_bus_if.slave bus
);

  mmc_pkg::mmc_tw_state_e state;
  logic scl_q;
  logic sda_q;
  logic [7:0] shift;
  logic [7:0] ptr;
  logic [3:0] cnt;
  logic rw;
  logic first;
  logic wrote;
  logic readd;
  logic nack;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  // one sample of the pins for edge and condition detection
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
    end
  end

  assign scl_rise = scl & ~scl_q;
  assign scl_fall = ~scl & scl_q;
  assign start_cond = scl & scl_q & sda_q & ~sda_in;
  assign stop_cond = scl & scl_q & ~sda_q & sda_in;
  assign bus.addr = ptr;
  assign bus.wdata = shift;

  // byte engine; pointer steps the cycle after each strobe so the
  // register bank sees the old pointer together with the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= mmc_pkg::MMC_TW_IDLE;
      shift <= 8'h00;
      ptr <= 8'h00;
      cnt <= 4'h0;
      rw <= 1'b0;
      first <= 1'b0;
      wrote <= 1'b0;
      readd <= 1'b0;
      nack <= 1'b0;
      sda_oe <= 1'b0;
      bus.wr_en <= 1'b0;
      bus.rd_en <= 1'b0;
      bus.stop_wr <= 1'b0;
      bus.stop_rd <= 1'b0;
    end else begin
      bus.wr_en <= 1'b0;
      bus.rd_en <= 1'b0;
      bus.stop_wr <= 1'b0;
      bus.stop_rd <= 1'b0;
      if (bus.wr_en || bus.rd_en) begin
        ptr <= ptr + 8'h01;
      end
      if (stop_cond) begin
        // read-clear effects of a transfer are timed from its stop
        state <= mmc_pkg::MMC_TW_IDLE;
        sda_oe <= 1'b0;
        bus.stop_wr <= wrote;
        bus.stop_rd <= readd;
        wrote <= 1'b0;
        readd <= 1'b0;
      end else if (start_cond) begin
        state <= mmc_pkg::MMC_TW_ADDR;
        cnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (!bus.enable) begin
        // deselected: let go of the line at once
        state <= mmc_pkg::MMC_TW_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          mmc_pkg::MMC_TW_ADDR: begin
            if (scl_rise) begin
              shift <= {shift[6:0], sda_in};
              cnt <= cnt + 4'h1;
            end else if (scl_fall && cnt == 4'h8) begin
              if (shift[7:1] == DEV_ADDR) begin
                state <= mmc_pkg::MMC_TW_AACK;
                sda_oe <= 1'b1;
                rw <= shift[0];
                first <= ~shift[0];
              end else begin
                state <= mmc_pkg::MMC_TW_IDLE;
              end
            end
          end
          mmc_pkg::MMC_TW_AACK: begin
            if (scl_fall) begin
              cnt <= 4'h0;
              if (rw) begin
                shift <= bus.rdata;
                sda_oe <= ~bus.rdata[7];
                bus.rd_en <= 1'b1;
                readd <= 1'b1;
                state <= mmc_pkg::MMC_TW_RBYTE;
              end else begin
                sda_oe <= 1'b0;
                state <= mmc_pkg::MMC_TW_WBYTE;
              end
            end
          end
          mmc_pkg::MMC_TW_WBYTE: begin
            if (scl_rise) begin
              shift <= {shift[6:0], sda_in};
              cnt <= cnt + 4'h1;
            end else if (scl_fall && cnt == 4'h8) begin
              state <= mmc_pkg::MMC_TW_WACK;
              sda_oe <= 1'b1;
              if (first) begin
                ptr <= shift; // first byte only sets the pointer
                first <= 1'b0;
              end else begin
                bus.wr_en <= 1'b1;
                wrote <= 1'b1;
              end
            end
          end
          mmc_pkg::MMC_TW_WACK: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              cnt <= 4'h0;
              state <= mmc_pkg::MMC_TW_WBYTE;
            end
          end
          mmc_pkg::MMC_TW_RBYTE: begin
            if (scl_fall) begin
              if (cnt == 4'h7) begin
                sda_oe <= 1'b0;
                state <= mmc_pkg::MMC_TW_RACK;
              end else begin
                shift <= {shift[6:0], 1'b0};
                sda_oe <= ~shift[6];
                cnt <= cnt + 4'h1;
              end
            end
          end
          mmc_pkg::MMC_TW_RACK: begin
            if (scl_rise) begin
              nack <= sda_in;
            end else if (scl_fall) begin
              cnt <= 4'h0;
              if (nack) begin
                state <= mmc_pkg::MMC_TW_IDLE;
              end else begin
                shift <= bus.rdata;
                sda_oe <= ~bus.rdata[7];
                bus.rd_en <= 1'b1;
                state <= mmc_pkg::MMC_TW_RBYTE;
              end
            end
          end
          default: begin
            state <= mmc_pkg::MMC_TW_IDLE;
          end
        endcase
      end
    end
  end

endmodule

// ### mmc_top.sv
// management control and status bank of a four-lane optical module
// assumes the host drives scl/sda and the control pins synchronous to clk
//
// How it works
// - tx recovery enables in control bits 7..4
// - rx recovery enables in control bits 3..0
// - amplitude codes 0..3 valid, rest reserved
// - equalization codes 0..10 dB, rest reserved
// - emphasis codes 0..7 dB, top bit reserved
// - fully functional within 2000 ms
// - reset pin low beyond 2 us resets
// - ready shown by clearing not-ready, raising interrupt
// - serial bus answers within 2000 ms
// - monitor data valid within 2000 ms
// - low-power pin enters low power quickly
// - interrupt asserted within 200 ms of cause
// - read-clear releases interrupt within 500 us
// - loss of signal flagged within 100 ms
// - transmit fault flagged within 200 ms
// - other flags set within 200 ms
// - masks gate interrupt within 100 ms
// - module select gates bus within 100 us
// - power override enters and leaves low power; the code ORs it with the pin, so it leaves only while the pin is low
// - write effects land at the write strobe, before its stop
`timescale 1ns/1ps
module mmc_top #(
  parameter int unsigned INIT_CYCLES = mmc_pkg::INIT_CYCLES_DEF,
  parameter logic [6:0] DEV_ADDR = mmc_pkg::DEV_ADDR_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic module_select_n,
  input wire logic module_reset_n,
  input wire logic low_power_pin,
  input wire logic [3:0] rx_los,
  input wire logic [3:0] tx_fault,
  output logic module_irq_n,
  output logic low_power_state,
  output logic data_not_ready,
  output logic [3:0] tx_recovery_en,
  output logic [3:0] rx_recovery_en,
  output logic [15:0] tx_eq_code,
  output logic [15:0] rx_emph_code,
  output logic [15:0] rx_amp_code
);

  mmc_bus_if bus ();

  mmc_pkg::mmc_state_e state;
  logic [7:0] low_cnt;
  logic pin_reset;
  logic soft_rst;
  logic [31:0] init_cnt;
  logic ready_flag;
  logic [3:0] los_flag;
  logic [3:0] txf_flag;
  logic [3:0] los_mask;
  logic [3:0] txf_mask;
  logic pwr_override;
  logic [7:0] cdr_lane_enable;
  logic [7:0] page;
  logic mark_status;
  logic mark_los;
  logic mark_txf;
  logic upper_ctrl;
  logic [15:0] next_eq;
  logic [15:0] next_emph;
  logic [15:0] next_amp;
  logic [7:0] next_rdata;

  mmc_twi_slave #(
    .DEV_ADDR(DEV_ADDR)
  ) u_slave (
    .clk(clk),
    .rst(soft_rst),
    .scl(scl),
    .sda_in(sda_in),
    .sda_oe(sda_oe),
    .bus(bus)
  );

  // reset pin filter: only a low level held past the least pulse counts,
  // so glitches on the pin cannot wipe the settings
  always_ff @(posedge clk) begin
    if (rst) begin
      low_cnt <= 8'h00;
      pin_reset <= 1'b0;
    end else if (module_reset_n) begin
      low_cnt <= 8'h00;
      pin_reset <= 1'b0;
    end else begin
      if (low_cnt != mmc_pkg::RESET_FILTER_CYCLES) begin
        low_cnt <= low_cnt + 8'h01;
      end
      pin_reset <= (low_cnt == mmc_pkg::RESET_FILTER_CYCLES);
    end
  end

  assign soft_rst = rst | pin_reset;

  // readiness sequence after power-on or a filtered pin reset
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      state <= mmc_pkg::MMC_ST_INIT;
      init_cnt <= 32'h00000000;
    end else begin
      case (state)
        mmc_pkg::MMC_ST_INIT: begin
          if (init_cnt == 32'(INIT_CYCLES - 1)) begin
            state <= mmc_pkg::MMC_ST_READY;
          end else begin
            init_cnt <= init_cnt + 32'h00000001;
          end
        end
        mmc_pkg::MMC_ST_READY: begin
          state <= mmc_pkg::MMC_ST_READY;
        end
        default: begin
          state <= mmc_pkg::MMC_ST_INIT;
        end
      endcase
    end
  end

  // not-ready bit follows the sequence; the interrupt side is below
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      data_not_ready <= 1'b1;
    end else begin
      data_not_ready <= (state != mmc_pkg::MMC_ST_READY);
    end
  end

  // bus answers once out of reset and only while selected; one cycle
  // of lag is far inside the select window
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      bus.enable <= 1'b0;
    end else begin
      bus.enable <= ~module_select_n;
    end
  end

  // remember which flag bytes a read touched; they clear at its stop
  always_ff @(posedge clk) begin
    if (soft_rst || bus.stop_rd) begin
      mark_status <= 1'b0;
      mark_los <= 1'b0;
      mark_txf <= 1'b0;
    end else if (bus.rd_en) begin
      if (bus.addr == mmc_pkg::OFS_STATUS) begin
        mark_status <= 1'b1;
      end else if (bus.addr == mmc_pkg::OFS_LOS_FLAG) begin
        mark_los <= 1'b1;
      end else if (bus.addr == mmc_pkg::OFS_TXF_FLAG) begin
        mark_txf <= 1'b1;
      end
    end
  end

  // latched flags: a new event in the clearing cycle survives the clear
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      ready_flag <= 1'b0;
      los_flag <= 4'h0;
      txf_flag <= 4'h0;
    end else begin
      ready_flag <= (ready_flag & ~(bus.stop_rd & mark_status))
        | (state == mmc_pkg::MMC_ST_INIT
           && init_cnt == 32'(INIT_CYCLES - 1));
      los_flag <= (los_flag & ~{4{bus.stop_rd & mark_los}})
        | rx_los;
      txf_flag <= (txf_flag & ~{4{bus.stop_rd & mark_txf}})
        | tx_fault;
    end
  end

  // open-drain interrupt, low while any unmasked flag stands
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      module_irq_n <= 1'b1;
    end else begin
      module_irq_n <= ~(ready_flag
        | (|(los_flag & ~los_mask))
        | (|(txf_flag & ~txf_mask)));
    end
  end

  // power level follows the pin and the override at once
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      low_power_state <= 1'b0;
    end else begin
      low_power_state <= low_power_pin | pwr_override;
    end
  end

  // pad of the open-drain pair: the pin is only ever pulled low
  always_ff @(posedge clk) begin
    sda_out <= 1'b0;
  end

  assign upper_ctrl = (page == mmc_pkg::PAGE_CTRL);

  // per-lane code update; a reserved code leaves that lane untouched
  // while the other lane of the same byte still takes its new code
  generate
    for (genvar l = 0; l < 4; l++) begin : g_lane
      localparam logic [7:0] BYTE_OFS = 8'(l / 2);
      localparam int unsigned NIB = 12 - 4 * l;
      logic [3:0] nib_in;
      logic hit_eq;
      logic hit_emph;
      logic hit_amp;
      assign nib_in = (l % 2 == 0) ? bus.wdata[7:4] : bus.wdata[3:0];
      assign hit_eq = bus.wr_en && upper_ctrl
        && bus.addr == mmc_pkg::OFS_TX_EQ + BYTE_OFS;
      assign hit_emph = bus.wr_en && upper_ctrl
        && bus.addr == mmc_pkg::OFS_RX_EMPH + BYTE_OFS;
      assign hit_amp = bus.wr_en && upper_ctrl
        && bus.addr == mmc_pkg::OFS_RX_AMP + BYTE_OFS;
      assign next_eq[NIB +: 4] =
        (hit_eq && nib_in <= mmc_pkg::EQ_MAX_CODE) ?
        nib_in : tx_eq_code[NIB +: 4];
      assign next_emph[NIB +: 4] =
        (hit_emph && nib_in <= mmc_pkg::EMPH_MAX_CODE) ?
        nib_in : rx_emph_code[NIB +: 4];
      assign next_amp[NIB +: 4] =
        (hit_amp && nib_in <= mmc_pkg::AMP_MAX_CODE) ?
        nib_in : rx_amp_code[NIB +: 4];
    end
  endgenerate

  // lane code registers
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      tx_eq_code <= mmc_pkg::RST_LANE_CODES;
      rx_emph_code <= mmc_pkg::RST_LANE_CODES;
      rx_amp_code <= mmc_pkg::RST_LANE_CODES;
    end else begin
      tx_eq_code <= next_eq;
      rx_emph_code <= next_emph;
      rx_amp_code <= next_amp;
    end
  end

  // plain control bytes of the lower page; writes land at the write's
  // own strobe, well before its stop
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      cdr_lane_enable <= mmc_pkg::RST_CDR;
      los_mask <= mmc_pkg::RST_MASK;
      txf_mask <= mmc_pkg::RST_MASK;
      pwr_override <= 1'b0;
      page <= mmc_pkg::RST_PAGE;
    end else if (bus.wr_en) begin
      if (bus.addr == mmc_pkg::OFS_CDR) begin
        cdr_lane_enable <= bus.wdata;
      end else if (bus.addr == mmc_pkg::OFS_LOS_MASK) begin
        los_mask <= bus.wdata[3:0];
      end else if (bus.addr == mmc_pkg::OFS_TXF_MASK) begin
        txf_mask <= bus.wdata[3:0];
      end else if (bus.addr == mmc_pkg::OFS_PWR_CTRL) begin
        pwr_override <= bus.wdata[mmc_pkg::BIT_PWR_OVERRIDE];
      end else if (bus.addr == mmc_pkg::OFS_PAGE) begin
        page <= bus.wdata;
      end
    end
  end

  // recovery enables: 1 runs the lane's recovery, 0 bypasses it
  assign tx_recovery_en = cdr_lane_enable[mmc_pkg::TX_CDR_LSB +: 4];
  assign rx_recovery_en = cdr_lane_enable[mmc_pkg::RX_CDR_LSB +: 4];

  // read mux; unmapped bytes read as zero
  always_comb begin
    next_rdata = 8'h00;
    if (bus.addr == mmc_pkg::OFS_STATUS) begin
      next_rdata[mmc_pkg::BIT_DATA_NOT_READY] = data_not_ready;
    end else if (bus.addr == mmc_pkg::OFS_LOS_FLAG) begin
      next_rdata = {4'h0, los_flag};
    end else if (bus.addr == mmc_pkg::OFS_TXF_FLAG) begin
      next_rdata = {4'h0, txf_flag};
    end else if (bus.addr == mmc_pkg::OFS_PWR_CTRL) begin
      next_rdata[mmc_pkg::BIT_PWR_OVERRIDE] = pwr_override;
    end else if (bus.addr == mmc_pkg::OFS_CDR) begin
      next_rdata = cdr_lane_enable;
    end else if (bus.addr == mmc_pkg::OFS_LOS_MASK) begin
      next_rdata = {4'h0, los_mask};
    end else if (bus.addr == mmc_pkg::OFS_TXF_MASK) begin
      next_rdata = {4'h0, txf_mask};
    end else if (bus.addr == mmc_pkg::OFS_PAGE) begin
      next_rdata = page;
    end else if (bus.addr >= mmc_pkg::UPPER_BASE && upper_ctrl) begin
      if (bus.addr == mmc_pkg::OFS_TX_EQ) begin
        next_rdata = tx_eq_code[15:8];
      end else if (bus.addr == mmc_pkg::OFS_TX_EQ + 8'h01) begin
        next_rdata = tx_eq_code[7:0];
      end else if (bus.addr == mmc_pkg::OFS_RX_EMPH) begin
        next_rdata = rx_emph_code[15:8];
      end else if (bus.addr == mmc_pkg::OFS_RX_EMPH + 8'h01) begin
        next_rdata = rx_emph_code[7:0];
      end else if (bus.addr == mmc_pkg::OFS_RX_AMP) begin
        next_rdata = rx_amp_code[15:8];
      end else if (bus.addr == mmc_pkg::OFS_RX_AMP + 8'h01) begin
        next_rdata = rx_amp_code[7:0];
      end
    end
  end

  // registered read data; the pointer holds for many cycles before use
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      bus.rdata <= 8'h00;
    end else begin
      bus.rdata <= next_rdata;
    end
  end

endmodule

// ### mmc_host_model.sv
// host controller side of the two-wire management bus
// assumes the bench forms the open-drain wire with a pull-up
`timescale 1ns/1ps
module mmc_host_model (
  input wire logic clk,
  input wire logic sda_in,
  output logic scl,
  output logic sda_drv
);
  // bus idles released, both lines high
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // one scl phase of four clocks, the slave's least phase
  task automatic tick();
    repeat (4) @(posedge clk);
    #2;
  endtask
  // start or repeated start: sda falls while scl is high
  task automatic start();
    sda_drv = 1'b1;
    tick();
    scl = 1'b1;
    tick();
    sda_drv = 1'b0;
    tick();
    scl = 1'b0;
    tick();
  endtask
  // stop: sda rises while scl is high
  task automatic stop();
    sda_drv = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    sda_drv = 1'b1;
    tick();
  endtask
  // sda moves a phase after scl falls, never beside an scl edge
  task automatic xbyte(input logic [7:0] tx, input logic ack_drv,
      output logic [7:0] rx, output logic acked);
    for (int i = 7; i >= -1; i--) begin
      sda_drv = (i < 0) ? ack_drv : tx[i];
      tick();
      scl = 1'b1;
      tick();
      if (i < 0) begin
        acked = !sda_in;
      end else begin
        rx[i] = sda_in;
      end
      scl = 1'b0;
      tick();
    end
  endtask
endmodule

// ### mmc_top_monitor.sv
// pin-level checks on the management control bank
// assumes the top module's port names and one clock domain
`timescale 1ns/1ps
module mmc_top_monitor #(
  parameter int unsigned INIT_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic module_reset_n,
  input wire logic module_select_n,
  input wire logic low_power_pin,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic module_irq_n,
  input wire logic low_power_state,
  input wire logic data_not_ready,
  input wire logic [3:0] tx_recovery_en,
  input wire logic [3:0] rx_recovery_en,
  input wire logic [15:0] tx_eq_code,
  input wire logic [15:0] rx_emph_code,
  input wire logic [15:0] rx_amp_code
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  int unsigned wait_cnt;
  logic [7:0] low_cnt;
  function automatic logic legal(logic [15:0] v, logic [3:0] mx);
    return v[15:12] <= mx && v[11:8] <= mx && v[7:4] <= mx && v[3:0] <= mx;
  endfunction
  // cycles not ready since either reset let go
  always_ff @(posedge clk) begin
    if (rst || !module_reset_n) begin
      wait_cnt <= 0;
    end else if (data_not_ready) begin
      wait_cnt <= wait_cnt + 1;
    end
  end
  // reset pin low time, saturating
  always_ff @(posedge clk) begin
    if (rst || module_reset_n) begin
      low_cnt <= 8'h00;
    end else if (low_cnt != 8'hff) begin
      low_cnt <= low_cnt + 8'h01;
    end
  end
  sequence ready_drop;
    $fell(data_not_ready);
  endsequence
  sequence select_off;
    module_select_n [*4];
  endsequence
  reset_values_a: assert property ($fell(rst) |-> data_not_ready &&
    module_irq_n && !low_power_state && tx_eq_code == 16'h0000 &&
    {tx_recovery_en, rx_recovery_en} == 8'h00)
    else $error("outputs not at reset values");
  init_deadline_a: assert property (data_not_ready |->
    wait_cnt <= INIT_CYCLES + 6) else $error("init took too long");
  init_early_a: assert property (ready_drop |->
    wait_cnt >= INIT_CYCLES) else $error("ready before init time");
  ready_irq_a: assert property (ready_drop |-> ##[0:2] !module_irq_n)
    else $error("ready without interrupt");
  pin_reset_a: assert property (low_cnt >= 8'h38 |->
    data_not_ready && module_irq_n && tx_recovery_en == 4'h0)
    else $error("long reset pin low ignored");
  low_power_a: assert property (low_power_pin && module_reset_n
    |=> low_power_state) else $error("low power pin not obeyed");
  select_off_a: assert property (select_off |-> !sda_oe)
    else $error("bus driven while not selected");
  sda_level_a: assert property (sda_oe |-> !sda_out &&
    !$past(module_select_n, 2)) else $error("bad sda drive");
  eq_legal_a: assert property (legal(tx_eq_code, 4'ha))
    else $error("reserved equalization applied");
  emph_legal_a: assert property (legal(rx_emph_code, 4'h7))
    else $error("reserved emphasis applied");
  amp_legal_a: assert property (legal(rx_amp_code, 4'h3))
    else $error("reserved amplitude applied");
endmodule

bind mmc_top mmc_top_monitor #(.INIT_CYCLES(INIT_CYCLES)) mon_u (
  .clk(clk), .rst(rst), .module_reset_n(module_reset_n),
  .module_select_n(module_select_n), .low_power_pin(low_power_pin),
  .sda_out(sda_out), .sda_oe(sda_oe), .module_irq_n(module_irq_n),
  .low_power_state(low_power_state), .data_not_ready(data_not_ready),
  .tx_recovery_en(tx_recovery_en), .rx_recovery_en(rx_recovery_en),
  .tx_eq_code(tx_eq_code), .rx_emph_code(rx_emph_code),
  .rx_amp_code(rx_amp_code)
);

// ### test_mmc_top.sv
// self-checking bench: host tasks on the two-wire bus and pins
// assumes the host model and the bound checker beside the design
`timescale 1ns/1ps
module test_mmc_top;
  localparam int unsigned INIT = 20;
  localparam logic [11:0] MAXES = {mmc_pkg::EQ_MAX_CODE,
    mmc_pkg::EMPH_MAX_CODE, mmc_pkg::AMP_MAX_CODE};
  localparam logic [6:0] DEV = mmc_pkg::DEV_ADDR_DEF;
  logic clk, rst, scl, sda_drv, sda_out, sda_oe, sel_n, mrst_n, lp_pin;
  logic irq_n, lp_state, dnr;
  logic [3:0] rx_los, tx_fault, tx_en, rx_en;
  logic [15:0] eq, emph, amp;
  logic [15:0] exp_codes [3];
  int num_errors, num_checks, cycles;
  wire logic sda_wire;
  wire logic [47:0] all_codes;
  // pull-up wire: low while either party pulls it down
  assign sda_wire = sda_drv & !(sda_oe && !sda_out);
  assign all_codes = {eq, emph, amp};
  mmc_host_model host_u (.clk(clk), .sda_in(sda_wire), .scl(scl),
    .sda_drv(sda_drv));
  mmc_top #(.INIT_CYCLES(INIT)) dut_u (.clk(clk), .rst(rst), .scl(scl),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
    .module_select_n(sel_n), .module_reset_n(mrst_n),
    .low_power_pin(lp_pin), .rx_los(rx_los), .tx_fault(tx_fault),
    .module_irq_n(irq_n), .low_power_state(lp_state),
    .data_not_ready(dnr), .tx_recovery_en(tx_en), .rx_recovery_en(rx_en),
    .tx_eq_code(eq), .rx_emph_code(emph), .rx_amp_code(amp));
  initial begin
    clk = 1'b0;
    forever #20 clk = !clk;
  end
  task automatic test_done();
    if (num_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // a hang costs one mismatch; the run needs about 40k cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] val,
      input logic exp_ack);
    logic [7:0] rb;
    logic a0, a1, a2;
    host_u.start();
    host_u.xbyte({DEV, 1'b0}, 1'b1, rb, a0);
    host_u.xbyte(ptr, 1'b1, rb, a1);
    host_u.xbyte(val, 1'b1, rb, a2);
    host_u.stop();
    chk(16'(a0 & a1 & a2), 16'(exp_ack));
  endtask
  // pointer write, repeated start, one byte read, nack
  task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
    logic [7:0] rb;
    logic a;
    host_u.start();
    host_u.xbyte({DEV, 1'b0}, 1'b1, rb, a);
    host_u.xbyte(ptr, 1'b1, rb, a);
    host_u.start();
    host_u.xbyte({DEV, 1'b1}, 1'b1, rb, a);
    host_u.xbyte(8'hff, 1'b1, rb, a);
    host_u.stop();
    chk(16'(rb), 16'(exp));
  endtask
  task automatic pins(input int n, input logic [15:0] exp);
    repeat (n) @(posedge clk);
    #2;
    chk({13'h0000, dnr, irq_n, lp_state}, exp);
  endtask
  initial begin
    {rst, sel_n, mrst_n, lp_pin, rx_los, tx_fault} = {4'b1010, 8'h00};
    exp_codes = '{default: mmc_pkg::RST_LANE_CODES};
    repeat (4) @(posedge clk);
    #2 rst = 1'b0;
    pins(INIT - 2, 16'h0006);
    pins(6, 16'h0000);
    rd(mmc_pkg::OFS_STATUS, 8'h00);
    pins(2, 16'h0002);
    rd(mmc_pkg::OFS_CDR, mmc_pkg::RST_CDR);
    wr(mmc_pkg::OFS_CDR, 8'h96, 1'b1);
    chk({8'h00, tx_en, rx_en}, 16'h0096);
    rd(mmc_pkg::OFS_CDR, 8'h96);
    rd(8'h10, 8'h00);
    wr(mmc_pkg::OFS_PAGE, mmc_pkg::PAGE_CTRL, 1'b1);
    for (int k = 0; k < 3; k++) begin
      for (int b = 0; b < 2; b++) begin
        for (int c = 0; c < 16; c++) begin
          wr(8'(mmc_pkg::OFS_TX_EQ + 2 * k + b), {4'(c), 4'h1}, 1'b1);
          if (4'(c) <= MAXES[11 - 4 * k -: 4]) begin
            exp_codes[k][15 - 8 * b -: 4] = 4'(c);
          end
          exp_codes[k][11 - 8 * b -: 4] = 4'h1;
          chk(all_codes[47 - 16 * k -: 16], exp_codes[k]);
        end
      end
    end
    rx_los = 4'h4;
    pins(3, 16'h0000);
    rx_los = 4'h0;
    rd(mmc_pkg::OFS_LOS_FLAG, 8'h04);
    pins(3, 16'h0002);
    wr(mmc_pkg::OFS_TXF_MASK, 8'h0f, 1'b1);
    tx_fault = 4'h1;
    pins(3, 16'h0002);
    tx_fault = 4'h0;
    rd(mmc_pkg::OFS_TXF_FLAG, 8'h01);
    wr(mmc_pkg::OFS_TXF_MASK, 8'h00, 1'b1);
    tx_fault = 4'h2;
    pins(3, 16'h0000);
    tx_fault = 4'h0;
    rd(mmc_pkg::OFS_TXF_FLAG, 8'h02);
    pins(3, 16'h0002);
    lp_pin = 1'b1;
    pins(2, 16'h0003);
    lp_pin = 1'b0;
    wr(mmc_pkg::OFS_PWR_CTRL, 8'h01, 1'b1);
    pins(0, 16'h0003);
    wr(mmc_pkg::OFS_PWR_CTRL, 8'h00, 1'b1);
    pins(0, 16'h0002);
    sel_n = 1'b1;
    wr(mmc_pkg::OFS_CDR, 8'h00, 1'b0);
    sel_n = 1'b0;
    rd(mmc_pkg::OFS_CDR, 8'h96);
    mrst_n = 1'b0;
    pins(40, 16'h0002);
    mrst_n = 1'b1;
    pins(2, 16'h0002);
    mrst_n = 1'b0;
    pins(60, 16'h0006);
    chk({8'h00, tx_en, rx_en}, 16'h0000);
    mrst_n = 1'b1;
    pins(INIT + 8, 16'h0000);
    test_done();
  end
endmodule
